// ### design/cpf_pkg.sv
// Constants and types for the crosspoint state report formatter
// Operation
// - Full formats: dash open, X closed
// - Full: one talk, or one row per talk
// - One space between adjacent full-grid columns
// - Text formats never emit carriage return or line feed
// - Inspect: closed points as row letter, digits
// - Inspect: comma separated, single talk
// - Condensed: column byte as two hex characters
// - Condensed: one talk, or one unit per talk
// - Binary: column byte sent raw
// - Binary: one talk, or one unit per talk
// - Stand-alone totals 641, 154, 76 bytes
// - Row talk 79 bytes, 9-byte unit header
// - Per-unit talks equal units present, up to 5
// - Reset or restore selects full single talk
// - Output only after setup readout query
// - Row A is LSB, row H is MSB
package cpf_pkg;

   localparam int unsigned ROWS           = 8;
   localparam int unsigned COLS_PER_UNIT  = 72;
   localparam int unsigned MAX_SLAVES     = 4;
   localparam int unsigned FULL_ROW_BYTES = 79;
   localparam int unsigned FULL_COLS      = (FULL_ROW_BYTES + 1) / 2;
   localparam int unsigned FULL_HDR_BYTES = 9;
   localparam int unsigned BIN_HDR_BYTES  = 3;
   localparam int unsigned HEX_HDR_CHARS  = 8;
   localparam int unsigned FIFO_DEPTH     = 8;
   localparam int unsigned FIFO_WIDTH     = 9;

   localparam logic [7:0]  CH_OPEN        = 8'h2D;
   localparam logic [7:0]  CH_CLOSED      = 8'h58;
   localparam logic [7:0]  CH_SPACE       = 8'h20;
   localparam logic [7:0]  CH_COMMA       = 8'h2C;
   localparam logic [7:0]  CH_ROW_A       = 8'h41;
   localparam logic [7:0]  CH_ZERO        = 8'h30;
   localparam logic [7:0]  CH_HEX_A       = 8'h37;
   localparam logic [39:0] TXT_MASTER     = 40'h5345545550;
   localparam logic [39:0] TXT_SLAVE      = 40'h534C415645;

   localparam logic [6:0]  LAST_UNIT_COL  = 7'(COLS_PER_UNIT - 1);
   localparam logic [6:0]  LAST_FULL_COL  = 7'(FULL_COLS - 1);
   localparam logic [2:0]  LAST_ROW       = 3'(ROWS - 1);
   localparam logic [2:0]  MAX_SLAVE_NUM  = 3'(MAX_SLAVES);
   localparam logic [3:0]  FULL_HDR_LAST  = 4'(FULL_HDR_BYTES - 1);
   localparam logic [3:0]  BIN_HDR_LAST   = 4'(BIN_HDR_BYTES - 1);
   localparam logic [3:0]  HEX_HDR_LAST   = 4'(HEX_HDR_CHARS - 1);
   localparam logic [3:0]  TXT_LEN        = 4'h5;

   typedef enum logic [2:0] {
      FMT_FULL_SINGLE_TALK        = 3'h0,
      FMT_FULL_ROW_PER_TALK       = 3'h1,
      FMT_INSPECT_LIST_A          = 3'h2,
      FMT_INSPECT_LIST_B          = 3'h3,
      FMT_CONDENSED_SINGLE_TALK   = 3'h4,
      FMT_CONDENSED_UNIT_PER_TALK = 3'h5,
      FMT_BINARY_SINGLE_TALK      = 3'h6,
      FMT_BINARY_UNIT_PER_TALK    = 3'h7
   } cpf_fmt_t;

   localparam cpf_fmt_t FMT_RESET = FMT_FULL_SINGLE_TALK;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_WAIT = 3'h1,
      ST_HDR  = 3'h2,
      ST_BODY = 3'h3,
      ST_CSUM = 3'h4,
      ST_END  = 3'h5
   } cpf_state_t;

endpackage

// ### design/cpf_dec3.sv
// Binary to three ASCII decimal digits
`timescale 1ns/100ps
`default_nettype none
module cpf_dec3 (
   input  wire logic [8:0] val,
   output logic      [7:0] dig_hund,
   output logic      [7:0] dig_tens,
   output logic      [7:0] dig_ones
);
   import cpf_pkg::*;

   always_comb begin
      dig_hund = CH_ZERO + 8'(val / 9'h064);
      dig_tens = CH_ZERO + 8'((val / 9'h00A) % 9'h00A);
      dig_ones = CH_ZERO + 8'(val % 9'h00A);
   end
endmodule
`default_nettype wire

// ### design/cpf_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module cpf_fifo #(
   parameter int unsigned W = cpf_pkg::FIFO_WIDTH,
   parameter int unsigned D = cpf_pkg::FIFO_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         ce,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   import cpf_pkg::*;

   localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
   localparam int unsigned CW = $clog2(D + 1);
   localparam logic [AW-1:0] PTR_LAST = AW'(D - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wptr;
      logic [AW-1:0]       rptr;
      logic [CW-1:0]       cnt;
   } cpf_fifo_st_t;

   cpf_fifo_st_t q, d;
   logic         wr;
   logic         rd;

   assign in_ready  = (q.cnt != CNT_FULL);
   assign out_valid = (q.cnt != '0);
   assign out_data  = q.mem[q.rptr];

   always_comb begin
      d  = q;
      wr = ce & in_valid & in_ready;
      rd = ce & out_valid & out_ready;
      if (wr) begin
         d.mem[q.wptr] = in_data;
         d.wptr = (q.wptr == PTR_LAST) ? '0 : q.wptr + 1'b1;
      end
      if (rd) begin
         d.rptr = (q.rptr == PTR_LAST) ? '0 : q.rptr + 1'b1;
      end
      if (wr && !rd) begin
         d.cnt = q.cnt + 1'b1;
      end else if (rd && !wr) begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// ### design/cpf_formatter.sv
// Crosspoint state report formatter: setup readout to talk byte stream
`timescale 1ns/100ps
`default_nettype none
module cpf_formatter #(
   parameter int unsigned FIFO_W = cpf_pkg::FIFO_WIDTH,
   parameter int unsigned FIFO_D = cpf_pkg::FIFO_DEPTH
) (
   input  wire logic            clk,
   input  wire logic            srst,
   input  wire logic            ce,
   input  wire logic            fmt_wr,
   input  wire cpf_pkg::cpf_fmt_t fmt_sel,
   input  wire logic            defaults_restore,
   input  wire logic            setup_readout_query,
   input  wire logic [7:0]      query_setup,
   input  wire logic [2:0]      slave_count,
   input  wire logic            talk_req,
   output logic      [2:0]      col_unit,
   output logic      [6:0]      col_index,
   input  wire logic [7:0]      col_bits,
   output logic      [7:0]      out_byte,
   output logic                 out_last,
   output logic                 out_valid,
   input  wire logic            out_ready,
   output logic                 busy,
   output logic                 talk_empty,
   output cpf_pkg::cpf_fmt_t    fmt_current
);
   import cpf_pkg::*;

   typedef struct packed {
      cpf_state_t st;
      cpf_state_t nxt;
      cpf_fmt_t   fmt;
      cpf_fmt_t   afmt;
      logic [2:0] unit_last;
      logic [2:0] unit;
      logic [2:0] row;
      logic [6:0] col;
      logic [2:0] pos;
      logic [3:0] hidx;
      logic [7:0] csum;
      logic       done;
      logic       any;
      logic [7:0] setup;
      logic [7:0] pend;
      logic       pend_v;
      logic       empty;
   } cpf_fmt_st_t;

   cpf_fmt_st_t q, d;

   logic        fifo_in_ready;
   logic        step;
   logic        emit;
   logic [7:0]  gen;
   logic        push;
   logic        push_last;
   logic        is_full;
   logic        is_insp;
   logic        is_hex;
   logic        split;
   logic [8:0]  colnum;
   logic [8:0]  dec_val;
   logic [7:0]  dig_hund;
   logic [7:0]  dig_tens;
   logic [7:0]  dig_ones;
   logic [39:0] hdr_txt;
   logic [31:0] hex_word;
   logic        seg_end;
   logic        adv_row;
   logic        closed;

   function automatic logic [7:0] hex_char(input logic [3:0] nib);
      hex_char = (nib < 4'hA) ? CH_ZERO + 8'(nib) : CH_HEX_A + 8'(nib);
   endfunction

   // Readout position drives the relay-state lookup
   assign col_unit    = q.unit;
   assign col_index   = q.col;
   assign busy        = (q.st != ST_IDLE);
   assign talk_empty  = q.empty;
   assign fmt_current = q.fmt;

   assign is_full = (q.afmt[2:1] == 2'b00);
   assign is_insp = (q.afmt[2:1] == 2'b01);
   assign is_hex  = (q.afmt[2:1] == 2'b10);
   assign split   = q.afmt[0] & ~is_insp;
   assign closed  = col_bits[q.row];

   // Global column number across units, counting from one
   assign colnum   = 9'(q.unit) * 9'(COLS_PER_UNIT) + 9'(q.col) + 9'h001;
   assign dec_val  = (q.st != ST_HDR) ? colnum :
                     (q.unit == 3'h0) ? {1'b0, q.setup} : {6'h00, q.unit};
   assign hdr_txt  = (q.unit == 3'h0) ? TXT_MASTER : TXT_SLAVE;
   assign hex_word = {8'h00, q.setup, 8'h00, 5'h00, q.unit};

   cpf_dec3 u_dec (
      .val      (dec_val),
      .dig_hund (dig_hund),
      .dig_tens (dig_tens),
      .dig_ones (dig_ones)
   );

   // One byte is held back so the talk's last byte can be flagged
   assign step = ce & (~q.pend_v | fifo_in_ready);

   always_comb begin
      d         = q;
      emit      = 1'b0;
      gen       = 8'h00;
      push      = 1'b0;
      push_last = 1'b0;
      seg_end   = 1'b0;
      adv_row   = 1'b0;
      d.empty   = 1'b0;
      if (fmt_wr) begin
         d.fmt = fmt_sel;
      end
      if (defaults_restore) begin
         d.fmt = FMT_RESET;
      end
      if (step) begin
         unique case (q.st)
            ST_IDLE: begin
               if (setup_readout_query) begin
                  d.afmt      = q.fmt;
                  d.unit_last = (slave_count > MAX_SLAVE_NUM) ? MAX_SLAVE_NUM
                                                               : slave_count;
                  d.setup     = query_setup;
                  d.unit      = 3'h0;
                  d.row       = 3'h0;
                  d.col       = 7'h00;
                  d.pos       = 3'h0;
                  d.hidx      = 4'h0;
                  d.done      = 1'b0;
                  d.any       = 1'b0;
                  d.st        = ST_WAIT;
                  d.nxt       = (q.fmt[2:1] == 2'b01) ? ST_BODY : ST_HDR;
               end
            end
            ST_WAIT: begin
               if (talk_req) begin
                  d.st = q.nxt;
               end
            end
            ST_HDR: begin
               emit   = 1'b1;
               d.hidx = q.hidx + 4'h1;
               if (is_full) begin
                  if (q.hidx < TXT_LEN) begin
                     gen = hdr_txt[8 * (4 - int'(q.hidx)) +: 8];
                  end else if (q.hidx == TXT_LEN) begin
                     gen = CH_SPACE;
                  end else if (q.hidx == TXT_LEN + 4'h1) begin
                     gen = dig_hund;
                  end else if (q.hidx == TXT_LEN + 4'h2) begin
                     gen = dig_tens;
                  end else begin
                     gen = dig_ones;
                  end
                  seg_end = (q.hidx == FULL_HDR_LAST);
               end else if (is_hex) begin
                  gen     = hex_char(hex_word[4 * (7 - int'(q.hidx)) +: 4]);
                  seg_end = (q.hidx == HEX_HDR_LAST);
               end else begin
                  gen     = (q.hidx == 4'h0) ? 8'h00 :
                            (q.hidx == 4'h1) ? q.setup : {5'h00, q.unit};
                  seg_end = (q.hidx == BIN_HDR_LAST);
               end
               if (seg_end) begin
                  d.hidx = 4'h0;
                  d.csum = 8'h00;
                  d.pos  = 3'h0;
                  if (is_full && split) begin
                     d.st  = ST_END;
                     d.nxt = ST_BODY;
                  end else begin
                     d.st = ST_BODY;
                  end
               end
            end
            ST_BODY: begin
               if (is_full) begin
                  emit = 1'b1;
                  if (q.pos == 3'h0) begin
                     gen = closed ? CH_CLOSED : CH_OPEN;
                     if (q.col != LAST_FULL_COL) begin
                        d.pos = 3'h1;
                     end else begin
                        d.col = 7'h00;
                        if (q.row != LAST_ROW) begin
                           d.row = q.row + 3'h1;
                           if (split) begin
                              d.st  = ST_END;
                              d.nxt = ST_BODY;
                           end
                        end else begin
                           d.row   = 3'h0;
                           seg_end = 1'b1;
                        end
                     end
                  end else begin
                     gen   = CH_SPACE;
                     d.pos = 3'h0;
                     d.col = q.col + 7'h01;
                  end
               end else if (is_insp) begin
                  if (!closed) begin
                     adv_row = 1'b1;
                  end else begin
                     d.pos = q.pos + 3'h1;
                     unique case (q.pos)
                        3'h0: begin
                           emit = q.any;
                           gen  = CH_COMMA;
                        end
                        3'h1: begin
                           emit = 1'b1;
                           gen  = CH_ROW_A + 8'(q.row);
                        end
                        3'h2: begin
                           emit = 1'b1;
                           gen  = dig_hund;
                        end
                        3'h3: begin
                           emit = 1'b1;
                           gen  = dig_tens;
                        end
                        default: begin
                           emit    = 1'b1;
                           gen     = dig_ones;
                           d.pos   = 3'h0;
                           d.any   = 1'b1;
                           adv_row = 1'b1;
                        end
                     endcase
                  end
               end else begin
                  emit = 1'b1;
                  if (is_hex) begin
                     gen   = hex_char(q.pos[0] ? col_bits[3:0] : col_bits[7:4]);
                     d.pos = q.pos[0] ? 3'h0 : 3'h1;
                  end else begin
                     gen = col_bits;
                  end
                  if (!is_hex || q.pos[0]) begin
                     d.csum = q.csum + col_bits;
                     if (q.col == LAST_UNIT_COL) begin
                        d.col = 7'h00;
                        d.pos = 3'h0;
                        d.st  = ST_CSUM;
                     end else begin
                        d.col = q.col + 7'h01;
                     end
                  end
               end
            end
            ST_CSUM: begin
               emit = 1'b1;
               if (is_hex) begin
                  gen     = hex_char(q.pos[0] ? q.csum[3:0] : q.csum[7:4]);
                  d.pos   = q.pos[0] ? 3'h0 : 3'h1;
                  seg_end = q.pos[0];
               end else begin
                  gen     = q.csum;
                  seg_end = 1'b1;
               end
            end
            ST_END: begin
               push      = q.pend_v;
               push_last = 1'b1;
               d.pend_v  = 1'b0;
               d.empty   = ~q.pend_v;
               d.st      = q.done ? ST_IDLE : ST_WAIT;
            end
            default: begin
               d.st = ST_IDLE;
            end
         endcase

         // Unit finished: next unit or end of readout
         if (seg_end && q.st != ST_HDR) begin
            d.nxt = ST_HDR;
            if (q.unit == q.unit_last) begin
               d.done = 1'b1;
               d.st   = ST_END;
            end else begin
               d.unit = q.unit + 3'h1;
               d.st   = split ? ST_END : ST_HDR;
            end
         end

         // Inspect walk: rows, then columns, then units
         if (adv_row) begin
            if (q.row != LAST_ROW) begin
               d.row = q.row + 3'h1;
            end else begin
               d.row = 3'h0;
               if (q.col != LAST_UNIT_COL) begin
                  d.col = q.col + 7'h01;
               end else begin
                  d.col = 7'h00;
                  if (q.unit == q.unit_last) begin
                     d.done = 1'b1;
                     d.st   = ST_END;
                  end else begin
                     d.unit = q.unit + 3'h1;
                  end
               end
            end
         end

         // No line breaks are generated here in text formats; binary bytes pass raw
         if (emit) begin
            push     = q.pend_v;
            d.pend   = gen;
            d.pend_v = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q      <= '0;
         q.fmt  <= FMT_RESET;
         q.afmt <= FMT_RESET;
         q.st   <= ST_IDLE;
         q.nxt  <= ST_HDR;
      end else if (ce) begin
         q <= d;
      end
   end

   cpf_fifo #(
      .W (FIFO_W),
      .D (FIFO_D)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   ({push_last, q.pend}),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  ({out_last, out_byte})
   );
endmodule
`default_nettype wire

// ### dv/cpf_formatter_asserts.sv
// Port-level checks for the report formatter
`timescale 1ns/100ps
`default_nettype none
module cpf_formatter_asserts #(
   parameter int unsigned FIFO_W = 9,
   parameter int unsigned FIFO_D = 8
) (
   input wire logic              clk,
   input wire logic              srst,
   input wire logic              ce,
   input wire logic              fmt_wr,
   input wire cpf_pkg::cpf_fmt_t fmt_sel,
   input wire logic              defaults_restore,
   input wire logic              setup_readout_query,
   input wire logic [7:0]        out_byte,
   input wire logic              out_last,
   input wire logic              out_valid,
   input wire logic              out_ready,
   input wire logic              busy,
   input wire logic              talk_empty,
   input wire cpf_pkg::cpf_fmt_t fmt_current
);
   import cpf_pkg::*;

   logic       take;
   cpf_fmt_t   fmt_l_q;
   logic [9:0] cnt_q;

   assign take = out_valid && out_ready && ce;

   // Format of the readout in flight, bytes taken so far in the talk
   always_ff @(posedge clk) begin
      if (srst) begin
         fmt_l_q <= FMT_RESET;
         cnt_q   <= 10'h000;
      end else begin
         if (setup_readout_query && ce && !busy)
            fmt_l_q <= fmt_current;
         if (take)
            cnt_q <= out_last ? 10'h000 : cnt_q + 10'h001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_reset_format: assert property ($fell(srst) |-> fmt_current == FMT_RESET)
      else $error("format not default after reset");
   chk_restore_format: assert property (defaults_restore && ce |=> fmt_current == FMT_RESET)
      else $error("restore did not select default format");
   chk_format_load: assert property (fmt_wr && !defaults_restore && ce
      |=> fmt_current == $past(fmt_sel))
      else $error("format write not loaded");
   chk_query_busy: assert property (setup_readout_query && ce && !busy |=> busy)
      else $error("query did not start readout");
   chk_quiet_idle: assert property (!busy && !out_valid && !setup_readout_query
      |=> !out_valid)
      else $error("output without a query");
   chk_byte_holds: assert property (out_valid && !(out_ready && ce)
      |=> out_valid && $stable(out_byte) && $stable(out_last))
      else $error("byte changed before taken");
   chk_no_line_breaks: assert property (out_valid && fmt_l_q < FMT_BINARY_SINGLE_TALK
      |-> out_byte != 8'h0D && out_byte != 8'h0A)
      else $error("line break in text output");
   chk_bin_unit_len: assert property (take && out_last
      && fmt_l_q == FMT_BINARY_UNIT_PER_TALK |-> cnt_q == 10'h04B)
      else $error("binary unit talk length wrong");
   chk_hex_unit_len: assert property (take && out_last
      && fmt_l_q == FMT_CONDENSED_UNIT_PER_TALK |-> cnt_q == 10'h099)
      else $error("condensed unit talk length wrong");
   chk_row_talk_len: assert property (take && out_last
      && fmt_l_q == FMT_FULL_ROW_PER_TALK |-> cnt_q == 10'h04E || cnt_q == 10'h008)
      else $error("row talk length wrong");

   cov_row_talk: cover property (take && out_last && fmt_l_q == FMT_FULL_ROW_PER_TALK);
   cov_empty_talk: cover property (talk_empty);
   cov_stall: cover property (out_valid && !out_ready);
endmodule

bind cpf_formatter cpf_formatter_asserts #(
   .FIFO_W(FIFO_W),
   .FIFO_D(FIFO_D)
) i_cpf_formatter_asserts (
   .clk(clk), .srst(srst), .ce(ce), .fmt_wr(fmt_wr), .fmt_sel(fmt_sel),
   .defaults_restore(defaults_restore), .setup_readout_query(setup_readout_query),
   .out_byte(out_byte), .out_last(out_last), .out_valid(out_valid),
   .out_ready(out_ready), .busy(busy), .talk_empty(talk_empty),
   .fmt_current(fmt_current)
);
`default_nettype wire

// ### dv/cpf_ctrl_model.sv
// Bus controller model: requests talks and reads bytes
`timescale 1ns/100ps
`default_nettype none
module cpf_ctrl_model (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic slow,
   input  wire logic busy,
   input  wire logic talk_empty,
   input  wire logic out_valid,
   input  wire logic out_last,
   output logic      talk_req,
   output logic      out_ready
);
   logic       in_talk_q;
   logic [1:0] ph_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         in_talk_q <= 1'b0;
         talk_req  <= 1'b0;
         out_ready <= 1'b0;
         ph_q      <= 2'h0;
      end else begin
         ph_q      <= ph_q + 2'h1;
         // Slow reader takes at most one byte in four
         out_ready <= !slow || ph_q == 2'h3;
         // Request held until seen on an enabled edge
         talk_req  <= talk_req && !ce;
         if (busy && !in_talk_q) begin
            talk_req  <= 1'b1;
            in_talk_q <= 1'b1;
         end
         // Talk ends at its last byte, an empty talk, or when not busy with no byte waiting
         if ((out_valid && out_ready && ce && out_last) || talk_empty
             || (!busy && !out_valid))
            in_talk_q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### dv/test_cpf_formatter.sv
// Self-checking bench for the report formatter
`timescale 1ns/100ps
`default_nettype none
module test_cpf_formatter;
   import cpf_pkg::*;
   logic       clk, srst, ce, fmt_wr, defaults_restore, setup_readout_query, slow;
   logic       talk_req, out_last, out_valid, out_ready, busy, talk_empty;
   logic [7:0] query_setup, col_bits, out_byte;
   logic [2:0] slave_count, col_unit;
   logic [6:0] col_index;
   cpf_fmt_t   fmt_sel, fmt_current;
   logic [7:0] mem [0:4][0:71];
   logic [7:0] q [$];
   int         err_count, n_tests, talks, cyc;

   assign col_bits = (col_unit < 3'h5 && col_index < 7'h48) ? mem[col_unit][col_index] : 8'h00;

   cpf_formatter i_cpf_formatter (
      .clk(clk), .srst(srst), .ce(ce), .fmt_wr(fmt_wr), .fmt_sel(fmt_sel),
      .defaults_restore(defaults_restore), .setup_readout_query(setup_readout_query),
      .query_setup(query_setup), .slave_count(slave_count), .talk_req(talk_req),
      .col_unit(col_unit), .col_index(col_index), .col_bits(col_bits),
      .out_byte(out_byte), .out_last(out_last), .out_valid(out_valid),
      .out_ready(out_ready), .busy(busy), .talk_empty(talk_empty),
      .fmt_current(fmt_current));

   cpf_ctrl_model i_cpf_ctrl_model (
      .clk(clk), .srst(srst), .ce(ce), .slow(slow), .busy(busy),
      .talk_empty(talk_empty), .out_valid(out_valid), .out_last(out_last),
      .talk_req(talk_req), .out_ready(out_ready));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Collect every byte taken and count finished talks
   always @(posedge clk) begin
      cyc++;
      if (out_valid === 1'b1 && out_ready === 1'b1 && ce === 1'b1) begin
         q.push_back(out_byte);
         if (out_last === 1'b1)
            talks++;
      end
      if (talk_empty === 1'b1)
         talks++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
   endfunction

   // One readout; x adds a refused query and a clock-enable gap
   task automatic rd(input cpf_fmt_t f, input logic [2:0] ns, input logic x);
      int n;
      n = 0;
      q.delete();
      talks = 0;
      @(posedge clk);
      fmt_wr <= 1'b1;
      fmt_sel <= f;
      @(posedge clk);
      fmt_wr <= 1'b0;
      setup_readout_query <= 1'b1;
      slave_count <= ns;
      @(posedge clk);
      setup_readout_query <= 1'b0;
      repeat (8) @(posedge clk);
      if (x) begin
         setup_readout_query <= 1'b1;
         @(posedge clk);
         setup_readout_query <= 1'b0;
         ce <= 1'b0;
         repeat (4) @(posedge clk);
         ce <= 1'b1;
      end
      while ((busy !== 1'b0 || out_valid !== 1'b0) && n < 10000) begin
         @(posedge clk);
         n++;
      end
      chk(n < 10000, 1);
      repeat (2) @(posedge clk);
   endtask

   task automatic t_binary();
      logic [7:0] sum;
      sum = 8'h00;
      rd(FMT_BINARY_SINGLE_TALK, 3'h0, 1'b1);
      chk(q.size(), 76);
      chk(talks, 1);
      for (int c = 0; c < 72; c++) begin
         chk(q[3 + c], mem[0][c]);
         sum = sum + mem[0][c];
      end
      chk(q[75], sum);
      slow <= 1'b1;
      rd(FMT_BINARY_UNIT_PER_TALK, 3'h4, 1'b0);
      slow <= 1'b0;
      chk(q.size(), 380);
      chk(talks, 5);
      chk(q[79], mem[1][0]);
      chk(q[312], mem[4][5]);
   endtask

   task automatic t_condensed();
      rd(FMT_CONDENSED_SINGLE_TALK, 3'h0, 1'b0);
      chk(q.size(), 154);
      chk(talks, 1);
      for (int c = 0; c < 72; c++) begin
         chk(q[8 + 2 * c], hx(mem[0][c][7:4]));
         chk(q[9 + 2 * c], hx(mem[0][c][3:0]));
      end
      rd(FMT_CONDENSED_UNIT_PER_TALK, 3'h1, 1'b1);
      chk(q.size(), 308);
      chk(talks, 2);
   endtask

   task automatic t_full();
      int bad;
      bad = 0;
      rd(FMT_FULL_SINGLE_TALK, 3'h0, 1'b0);
      chk(q.size(), 641);
      chk(talks, 1);
      foreach (q[i])
         if (q[i] == 8'h0D || q[i] == 8'h0A)
            bad++;
      chk(bad, 0);
      for (int r = 0; r < 8; r++) begin
         for (int c = 0; c < 40; c++) begin
            chk(q[9 + 79 * r + 2 * c], mem[0][c][r] ? 8'h58 : 8'h2D);
            if (c < 39)
               chk(q[10 + 79 * r + 2 * c], 8'h20);
         end
      end
      rd(FMT_FULL_ROW_PER_TALK, 3'h1, 1'b1);
      chk(talks, 18);
      chk(q.size(), 1282);
      chk(q[9], 8'h58);
   endtask

   task automatic t_inspect();
      string exp;
      exp = "A001,B003,H003,E073";
      for (int f = 2; f < 4; f++) begin
         rd(cpf_fmt_t'(f), 3'h1, 1'b0);
         chk(talks, 1);
         chk(q.size(), exp.len());
         for (int i = 0; i < exp.len(); i++)
            chk(q[i], exp[i]);
      end
      mem[0][0] = 8'h00;
      mem[0][2] = 8'h00;
      rd(FMT_INSPECT_LIST_A, 3'h0, 1'b0);
      chk(talks, 1);
      chk(q.size(), 0);
   endtask

   task automatic t_restore();
      @(posedge clk);
      fmt_wr <= 1'b1;
      fmt_sel <= FMT_CONDENSED_UNIT_PER_TALK;
      @(posedge clk);
      fmt_wr <= 1'b0;
      @(posedge clk);
      chk(fmt_current, FMT_CONDENSED_UNIT_PER_TALK);
      defaults_restore <= 1'b1;
      fmt_wr <= 1'b1;
      @(posedge clk);
      defaults_restore <= 1'b0;
      fmt_wr <= 1'b0;
      @(posedge clk);
      chk(fmt_current, FMT_RESET);
   endtask

   initial begin
      srst = 1'b1;
      ce = 1'b1;
      fmt_wr = 1'b0;
      fmt_sel = FMT_RESET;
      defaults_restore = 1'b0;
      setup_readout_query = 1'b0;
      slow = 1'b0;
      query_setup = 8'h03;
      slave_count = 3'h0;
      err_count = 0;
      n_tests = 0;
      cyc = 0;
      talks = 0;
      foreach (mem[u, c])
         mem[u][c] = 8'h00;
      mem[0][0] = 8'h01;
      mem[0][2] = 8'h82;
      mem[1][0] = 8'h10;
      mem[4][5] = 8'h5A;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(fmt_current, FMT_RESET);
      chk(out_valid, 1'b0);
      t_binary();
      t_condensed();
      t_full();
      t_inspect();
      t_restore();
      end_sim();
   end
endmodule
`default_nettype wire
